// File: rtl/crre_consts.svh
`ifndef CRRE_CONSTS_SVH
`define CRRE_CONSTS_SVH

// widths and sizes
`define CRRE_PC_W         21
`define CRRE_STACK_DEPTH  31
`define CRRE_PTR_W        5
`define CRRE_PC_STEP      21'h000002
`define CRRE_PC_RESET     21'h000000

// instruction encodings
`define CRRE_CALL_PREFIX  5'h1b
`define CRRE_LRET_PREFIX  8'h0c
`define CRRE_IRET_BASE    15'h0008
`define CRRE_SWRST_WORD   16'h00ff
`define CRRE_NOP_WORD     16'h0000

// register byte offsets
`define CRRE_OFF_CTRL     12'h000
`define CRRE_OFF_ACC      12'h004
`define CRRE_OFF_STATUS   12'h008
`define CRRE_OFF_BANK     12'h00c
`define CRRE_OFF_ACC_SH   12'h010
`define CRRE_OFF_STAT_SH  12'h014
`define CRRE_OFF_BANK_SH  12'h018
`define CRRE_OFF_ENABLE   12'h01c
`define CRRE_OFF_UPLATCH  12'h020
`define CRRE_OFF_HILATCH  12'h024
`define CRRE_OFF_PC       12'h028
`define CRRE_OFF_STACK    12'h02c

// field positions in the enable register
`define CRRE_EN_LO_BIT    0
`define CRRE_EN_HI_BIT    1

// reset values
`define CRRE_BYTE_RESET   8'h00
`define CRRE_STAT_RESET   5'h00
`define CRRE_BANK_RESET   4'h0

`endif

// File: rtl/crre_pkg.sv
package crre_pkg;

   typedef enum {CRRE_Q1, CRRE_Q2, CRRE_Q3, CRRE_Q4} crre_phase_t;

   typedef enum {
      OP_OTHER,
      OP_RELATIVE_CALL,
      OP_SOFT_RESET,
      OP_INTERRUPT_RETURN,
      OP_LITERAL_RETURN
   } crre_op_t;

endpackage

// File: rtl/crre_phase.sv
`timescale 1ns/1ps
module crre_phase
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          run,
   output crre_pkg::crre_phase_t phase
);
   import crre_pkg::*;

   crre_phase_t next_phase;

   // phase holds while the core is stopped so a cycle resumes where it left
   always_comb
   begin
      unique case (phase)
         CRRE_Q1: next_phase = CRRE_Q2;
         CRRE_Q2: next_phase = CRRE_Q3;
         CRRE_Q3: next_phase = CRRE_Q4;
         CRRE_Q4: next_phase = CRRE_Q1;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         phase <= CRRE_Q1;
      else if (run)
         phase <= next_phase;
   end
endmodule

// File: rtl/crre_stack.sv
`timescale 1ns/1ps
`include "crre_consts.svh"
module crre_stack
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   push,
   input  wire logic                   pop,
   input  wire logic [`CRRE_PC_W-1:0]  push_data,
   output logic      [`CRRE_PC_W-1:0]  head,
   output logic      [`CRRE_PTR_W-1:0] depth
);
   logic [`CRRE_PC_W-1:0]  mem [0:`CRRE_STACK_DEPTH-1];
   logic [`CRRE_PTR_W-1:0] next_depth;
   logic                   can_push;
   logic                   can_pop;

   // overflow and underflow saturate; neither is flagged
   assign can_push = push && (depth != 5'(`CRRE_STACK_DEPTH));
   assign can_pop  = pop && (depth != 5'h00);
   assign next_depth = can_push ? depth + 5'h01 :
                       can_pop  ? depth - 5'h01 : depth;
   assign head = (depth == 5'h00) ? `CRRE_PC_RESET : mem[depth - 5'h01];

   always_ff @(posedge clk)
   begin
      if (can_push)
         mem[depth] <= push_data;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         depth <= 5'h00;
      else
         depth <= next_depth;
   end
endmodule

// File: rtl/crre_exec.sv
// What this block does
// - relative call is one word, top five bits 11011, eleven-bit signed offset
// - relative call pushes its address plus two as the new stack head
// - relative call then sets counter to address plus two plus twice offset
// - relative call takes two cycles, touches no flags, second cycle idle
// - software reset takes one cycle, starts in Q2, restores all reset values except the run bit
// - interrupt return is 0x0010 plus bit s selecting shadow restore
// - interrupt return pops the stack and loads the head into the counter
// - interrupt return sets one global enable bit and no other status
// - with s set, interrupt return restores accumulator, flags and bank
// - with s clear, accumulator, flags and bank are left alone
// - returns never touch the upper or high counter latches
// - literal return has upper byte 0x0c and an eight-bit literal
// - literal return writes literal to accumulator in Q4, flags untouched
// - literal return pops stack into counter, two cycles, second idle
`timescale 1ns/1ps
`include "crre_consts.svh"
module crre_exec
(
   input  wire logic                  REF_CLK,
   input  wire logic                  RESET,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [11:0]           PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic      [31:0]           PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   input  wire logic [15:0]           INSTR,
   output logic      [`CRRE_PC_W-1:0] FETCH_ADDR,
   output crre_pkg::crre_phase_t      CORE_PHASE,
   output logic                       SOFT_RESET
);
   import crre_pkg::*;

   function automatic crre_op_t decode_op(input logic [15:0] w);
      crre_op_t op;
      op = OP_OTHER;
      if (w[15:11] == `CRRE_CALL_PREFIX)
         op = OP_RELATIVE_CALL;
      else if (w == `CRRE_SWRST_WORD)
         op = OP_SOFT_RESET;
      else if (w[15:1] == `CRRE_IRET_BASE)
         op = OP_INTERRUPT_RETURN;
      else if (w[15:8] == `CRRE_LRET_PREFIX)
         op = OP_LITERAL_RETURN;
      return op;
   endfunction

   function automatic logic is_mapped(input logic [11:0] a);
      return a <= `CRRE_OFF_STACK && a[1:0] == 2'b00;
   endfunction

   // core state
   logic                   run;
   logic [15:0]            ir;
   logic [`CRRE_PC_W-1:0]  pc;
   logic                   flush;
   logic [7:0]             acc;
   logic [4:0]             status;
   logic [3:0]             bank;
   logic [7:0]             acc_sh;
   logic [4:0]             status_sh;
   logic [3:0]             bank_sh;
   logic                   en_hi;
   logic                   en_lo;
   logic [4:0]             upper_pc_latch;
   logic [7:0]             high_pc_latch;

   // decode and control wires
   crre_phase_t            phase;
   crre_op_t               op;
   logic                   soft_rst;
   logic                   in_q1;
   logic                   in_q2;
   logic                   in_q4;
   logic                   is_call;
   logic                   is_iret;
   logic                   is_lret;
   logic                   do_ret;
   logic                   restore;
   logic                   two_cycle;
   logic [7:0]             lit_k;
   logic [`CRRE_PC_W-1:0]  call_disp;
   logic [`CRRE_PC_W-1:0]  call_target;
   logic [`CRRE_PC_W-1:0]  stack_head;
   logic [`CRRE_PTR_W-1:0] stack_depth;
   logic                   stack_push;
   logic                   stack_pop;

   // next values
   logic                   next_run;
   logic [15:0]            next_ir;
   logic [`CRRE_PC_W-1:0]  next_pc;
   logic                   next_flush;
   logic [7:0]             next_acc;
   logic [4:0]             next_status;
   logic [3:0]             next_bank;
   logic [7:0]             next_acc_sh;
   logic [4:0]             next_status_sh;
   logic [3:0]             next_bank_sh;
   logic                   next_en_hi;
   logic                   next_en_lo;
   logic [4:0]             next_upper;
   logic [7:0]             next_high;

   // bus wires
   logic                   apb_setup;
   logic                   apb_wr;
   logic [31:0]            rd_mux;
   logic                   wr_ctrl;
   logic                   wr_acc;
   logic                   wr_status;
   logic                   wr_bank;
   logic                   wr_acc_sh;
   logic                   wr_stat_sh;
   logic                   wr_bank_sh;
   logic                   wr_enable;
   logic                   wr_upper;
   logic                   wr_high;

   crre_phase u_phase
   (
      .clk   (REF_CLK),
      .rst   (soft_rst),
      .run   (run),
      .phase (phase)
   );

   crre_stack u_stack
   (
      .clk       (REF_CLK),
      .rst       (soft_rst),
      .push      (stack_push),
      .pop       (stack_pop),
      .push_data (pc),
      .head      (stack_head),
      .depth     (stack_depth)
   );

   assign op        = decode_op(ir);
   assign in_q1     = run && phase == CRRE_Q1;
   assign in_q2     = run && phase == CRRE_Q2;
   assign in_q4     = run && phase == CRRE_Q4;
   assign is_call   = op == OP_RELATIVE_CALL;
   assign is_iret   = op == OP_INTERRUPT_RETURN;
   assign is_lret   = op == OP_LITERAL_RETURN;
   assign do_ret    = in_q4 && (is_iret || is_lret);
   assign restore   = in_q4 && is_iret && ir[0];
   assign two_cycle = is_call || is_iret || is_lret;
   assign lit_k     = ir[7:0];

   // reset instruction acts at the Q2 edge and also restarts the phase
   assign soft_rst = RESET || (in_q2 && op == OP_SOFT_RESET);

   // pc already points past the call, so the target is pc plus 2n
   assign call_disp   = {{9{ir[10]}}, ir[10:0], 1'b0};
   assign call_target = pc + call_disp;

   assign stack_push = in_q2 && is_call;
   assign stack_pop  = do_ret;

   // the word prefetched in the first cycle is thrown away in the idle cycle, not executed
   assign next_ir = (in_q1 && flush)  ? `CRRE_NOP_WORD :
                    in_q1             ? INSTR : ir;
   assign next_flush = (in_q4 && two_cycle) ? 1'b1 :
                       (in_q1)            ? 1'b0 : flush;
   assign next_pc = (in_q4 && is_call)  ? call_target :
                    do_ret              ? stack_head :
                    (in_q1 && !flush)   ? pc + `CRRE_PC_STEP : pc;

   // bus side: zero wait states, read data captured in the setup phase
   assign apb_setup  = PSEL && !PENABLE;
   assign apb_wr     = PSEL && PENABLE && PWRITE;
   assign wr_ctrl    = apb_wr && PADDR == `CRRE_OFF_CTRL;
   assign wr_acc     = apb_wr && PADDR == `CRRE_OFF_ACC;
   assign wr_status  = apb_wr && PADDR == `CRRE_OFF_STATUS;
   assign wr_bank    = apb_wr && PADDR == `CRRE_OFF_BANK;
   assign wr_acc_sh  = apb_wr && PADDR == `CRRE_OFF_ACC_SH;
   assign wr_stat_sh = apb_wr && PADDR == `CRRE_OFF_STAT_SH;
   assign wr_bank_sh = apb_wr && PADDR == `CRRE_OFF_BANK_SH;
   assign wr_enable  = apb_wr && PADDR == `CRRE_OFF_ENABLE;
   assign wr_upper   = apb_wr && PADDR == `CRRE_OFF_UPLATCH;
   assign wr_high    = apb_wr && PADDR == `CRRE_OFF_HILATCH;
   assign PREADY     = 1'b1;

   assign rd_mux =
      (PADDR == `CRRE_OFF_CTRL)    ? {31'h0, run} :
      (PADDR == `CRRE_OFF_ACC)     ? {24'h0, acc} :
      (PADDR == `CRRE_OFF_STATUS)  ? {27'h0, status} :
      (PADDR == `CRRE_OFF_BANK)    ? {28'h0, bank} :
      (PADDR == `CRRE_OFF_ACC_SH)  ? {24'h0, acc_sh} :
      (PADDR == `CRRE_OFF_STAT_SH) ? {27'h0, status_sh} :
      (PADDR == `CRRE_OFF_BANK_SH) ? {28'h0, bank_sh} :
      (PADDR == `CRRE_OFF_ENABLE)  ? {30'h0, en_hi, en_lo} :
      (PADDR == `CRRE_OFF_UPLATCH) ? {27'h0, upper_pc_latch} :
      (PADDR == `CRRE_OFF_HILATCH) ? {24'h0, high_pc_latch} :
      (PADDR == `CRRE_OFF_PC)      ? {11'h0, pc} :
      (PADDR == `CRRE_OFF_STACK)   ? {3'h0, stack_depth, 3'h0, stack_head} :
                                     32'h0;

   // core updates win over a bus write landing on the same edge
   assign next_run = wr_ctrl ? PWDATA[0] : run;
   assign next_acc = is_lret && in_q4 ? lit_k :
                     restore          ? acc_sh :
                     wr_acc           ? PWDATA[7:0] : acc;
   assign next_status = restore   ? status_sh :
                        wr_status ? PWDATA[4:0] : status;
   assign next_bank   = restore ? bank_sh :
                        wr_bank ? PWDATA[3:0] : bank;
   assign next_acc_sh    = wr_acc_sh  ? PWDATA[7:0] : acc_sh;
   assign next_status_sh = wr_stat_sh ? PWDATA[4:0] : status_sh;
   assign next_bank_sh   = wr_bank_sh ? PWDATA[3:0] : bank_sh;

   // high priority comes back first; low is set only once high is on
   assign next_en_hi = (in_q4 && is_iret && !en_hi) ? 1'b1 :
                       wr_enable ? PWDATA[`CRRE_EN_HI_BIT] : en_hi;
   assign next_en_lo = (in_q4 && is_iret && en_hi) ? 1'b1 :
                       wr_enable ? PWDATA[`CRRE_EN_LO_BIT] : en_lo;
   assign next_upper  = wr_upper ? PWDATA[4:0] : upper_pc_latch;
   assign next_high   = wr_high  ? PWDATA[7:0] : high_pc_latch;

   always_ff @(posedge REF_CLK)
   begin
      if (soft_rst)
      begin
         ir    <= `CRRE_NOP_WORD;
         pc    <= `CRRE_PC_RESET;
         flush <= 1'b0;
      end
      else
      begin
         ir    <= next_ir;
         pc    <= next_pc;
         flush <= next_flush;
      end
   end

   // a software reset leaves the run bit alone so the core restarts at zero
   always_ff @(posedge REF_CLK)
   begin
      if (RESET)
         run <= 1'b0;
      else
         run <= next_run;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (soft_rst)
      begin
         acc            <= `CRRE_BYTE_RESET;
         status         <= `CRRE_STAT_RESET;
         bank           <= `CRRE_BANK_RESET;
         acc_sh         <= `CRRE_BYTE_RESET;
         status_sh      <= `CRRE_STAT_RESET;
         bank_sh        <= `CRRE_BANK_RESET;
         en_hi          <= 1'b0;
         en_lo          <= 1'b0;
         upper_pc_latch <= `CRRE_STAT_RESET;
         high_pc_latch  <= `CRRE_BYTE_RESET;
      end
      else
      begin
         acc            <= next_acc;
         status         <= next_status;
         bank           <= next_bank;
         acc_sh         <= next_acc_sh;
         status_sh      <= next_status_sh;
         bank_sh        <= next_bank_sh;
         en_hi          <= next_en_hi;
         en_lo          <= next_en_lo;
         upper_pc_latch <= next_upper;
         high_pc_latch  <= next_high;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         PRDATA     <= 32'h0;
         PSLVERR    <= 1'b0;
         SOFT_RESET <= 1'b0;
      end
      else
      begin
         PRDATA     <= apb_setup ? rd_mux : PRDATA;
         PSLVERR    <= apb_setup ? !is_mapped(PADDR) : PSLVERR;
         SOFT_RESET <= soft_rst;
      end
   end

   assign FETCH_ADDR = pc;
   assign CORE_PHASE = phase;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (soft_rst);

   sequence ret_q4_s;
      in_q4 && (is_iret || is_lret) && !apb_wr;
   endsequence

   sequence idle_cycle_s;
      ##3 (ir == `CRRE_NOP_WORD) ##1 1'b1;
   endsequence

   call_push_a: assert property (
      in_q2 && is_call |=> stack_head == $past(pc))
      else $error("call did not push return address");

   call_target_a: assert property (
      in_q4 && is_call |=> pc == $past(stack_head) + $past(call_disp))
      else $error("call target wrong");

   call_flags_a: assert property (
      in_q4 && is_call && !apb_wr |=> status == $past(status)
         && acc == $past(acc))
      else $error("call changed flags");

   flush_nop_a: assert property (
      in_q4 && two_cycle && run && !apb_wr
         |=> idle_cycle_s ##0 pc == $past(pc, 4))
      else $error("prefetched word not discarded");

   sw_reset_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      in_q2 && op == OP_SOFT_RESET
         |=> pc == `CRRE_PC_RESET && acc == `CRRE_BYTE_RESET
            && !en_hi && !en_lo && phase == CRRE_Q1 && SOFT_RESET)
      else $error("software reset incomplete");

   iret_pop_a: assert property (
      in_q4 && is_iret && !apb_wr
         |=> pc == $past(stack_head) && (en_hi || en_lo)
            && $past(stack_depth) != stack_depth + 5'h01 == 1'b0)
      else $error("interrupt return pop wrong");

   iret_enable_a: assert property (
      in_q4 && is_iret && !apb_wr && !en_hi
         |=> en_hi && en_lo == $past(en_lo))
      else $error("high enable not set");

   iret_low_a: assert property (
      in_q4 && is_iret && !apb_wr && en_hi |=> en_hi && en_lo)
      else $error("low enable not set");

   shadow_restore_a: assert property (
      restore |=> acc == $past(acc_sh) && status == $past(status_sh)
         && bank == $past(bank_sh))
      else $error("shadow restore missing");

   no_restore_a: assert property (
      in_q4 && is_iret && !ir[0] && !apb_wr
         |=> $stable(acc) && $stable(status) && $stable(bank))
      else $error("registers changed without s");

   latch_keep_a: assert property (
      ret_q4_s |=> $stable(upper_pc_latch) && $stable(high_pc_latch))
      else $error("counter latches modified");

   lit_return_a: assert property (
      in_q4 && is_lret && !wr_status |=> acc == $past(lit_k)
         && pc == $past(stack_head) && status == $past(status))
      else $error("literal return wrong");
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
`include "crre_consts.svh"
module testbench;
   import crre_pkg::*;
   logic                  REF_CLK;
   logic                  RESET;
   logic                  PSEL;
   logic                  PENABLE;
   logic                  PWRITE;
   logic [11:0]           PADDR;
   logic [31:0]           PWDATA;
   logic [31:0]           PRDATA;
   logic                  PREADY;
   logic                  PSLVERR;
   logic [15:0]           INSTR;
   logic [`CRRE_PC_W-1:0] FETCH_ADDR;
   crre_phase_t           CORE_PHASE;
   logic                  SOFT_RESET;
   logic [15:0]           mem [0:2047];
   logic [31:0]           rdata;
   logic                  err;
   int                    fail_count;
   int                    n_compared;

   crre_exec i_dut
   (
      .REF_CLK    (REF_CLK),
      .RESET      (RESET),
      .PSEL       (PSEL),
      .PENABLE    (PENABLE),
      .PWRITE     (PWRITE),
      .PADDR      (PADDR),
      .PWDATA     (PWDATA),
      .PRDATA     (PRDATA),
      .PREADY     (PREADY),
      .PSLVERR    (PSLVERR),
      .INSTR      (INSTR),
      .FETCH_ADDR (FETCH_ADDR),
      .CORE_PHASE (CORE_PHASE),
      .SOFT_RESET (SOFT_RESET)
   );

   initial
   begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end

   // program memory answers the fetch address one edge later
   always @(posedge REF_CLK)
      INSTR <= mem[FETCH_ADDR[11:1]];

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge REF_CLK);
      PSEL    <= 1'b1;
      PWRITE  <= wr;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      // only the watchdog ends a slave that never answers
      do
         @(posedge REF_CLK);
      while (PREADY !== 1'b1);
      rdata = PRDATA;
      err   = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                     input string what);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rdata);
   endtask

   task automatic do_reset();
      RESET <= 1'b1;
      repeat (8) @(posedge REF_CLK);
      RESET <= 1'b0;
      for (int i = 0; i < 2048; i++)
         mem[i] = `CRRE_NOP_WORD;
   endtask

   // bounded wait for the counter to reach t; returns cycles spent
   task automatic wait_pc(input logic [20:0] t, output int cyc);
      cyc = 0;
      do
      begin
         @(negedge REF_CLK);
         cyc++;
      end
      while (FETCH_ADDR !== t && cyc < 300);
      chk("fetch address", {11'h0, t}, {11'h0, FETCH_ADDR});
   endtask

   task automatic t_regs();
      rd(`CRRE_OFF_ACC, 32'h0, "acc reset");
      rd(`CRRE_OFF_STATUS, 32'h0, "status reset");
      rd(`CRRE_OFF_BANK, 32'h0, "bank reset");
      rd(`CRRE_OFF_ENABLE, 32'h0, "enables reset");
      chk("ready", 32'h1, {31'h0, PREADY});
      apb(1'b1, `CRRE_OFF_PC, 32'h40);
      rd(`CRRE_OFF_PC, 32'h0, "pc read only");
      rd(12'h030, 32'h0, "unmapped read");
      chk("unmapped error", 32'h1, {31'h0, err});
      rd(12'h006, 32'h0, "unaligned read");
      chk("unaligned error", 32'h1, {31'h0, err});
      $display("test regs done");
   endtask

   // call at 0 with offset n; words at the target are no-ops
   task automatic t_call(input logic [10:0] n);
      logic [20:0] tgt;
      int          c;
      tgt = 21'd2 + {{9{n[10]}}, n, 1'b0};
      do_reset();
      mem[0] = {`CRRE_CALL_PREFIX, n};
      apb(1'b1, `CRRE_OFF_STATUS, 32'h15);
      apb(1'b1, `CRRE_OFF_CTRL, 32'h1);
      wait_pc(tgt, c);
      wait_pc(tgt + 21'd2, c);
      chk("cycles to next fetch", 32'd5, c);
      apb(1'b1, `CRRE_OFF_CTRL, 32'h0);
      rd(`CRRE_OFF_STACK, 32'h01000002, "stack after call");
      rd(`CRRE_OFF_STATUS, 32'h15, "status after call");
      $display("test call %h done", n);
   endtask

   // literal return; the word after it would clobber acc if run
   task automatic t_lret();
      int c;
      do_reset();
      mem[0]   = {`CRRE_CALL_PREFIX, 11'd100};
      mem[101] = {`CRRE_LRET_PREFIX, 8'ha5};
      mem[102] = {`CRRE_LRET_PREFIX, 8'h55};
      apb(1'b1, `CRRE_OFF_STATUS, 32'h0a);
      apb(1'b1, `CRRE_OFF_UPLATCH, 32'h1f);
      apb(1'b1, `CRRE_OFF_HILATCH, 32'hab);
      apb(1'b1, `CRRE_OFF_CTRL, 32'h1);
      wait_pc(21'd202, c);
      wait_pc(21'd2, c);
      apb(1'b1, `CRRE_OFF_CTRL, 32'h0);
      rd(`CRRE_OFF_ACC, 32'ha5, "acc literal");
      rd(`CRRE_OFF_STACK, 32'h0, "stack popped");
      rd(`CRRE_OFF_STATUS, 32'h0a, "status kept");
      rd(`CRRE_OFF_UPLATCH, 32'h1f, "upper latch");
      rd(`CRRE_OFF_HILATCH, 32'hab, "high latch");
      $display("test literal return done");
   endtask

   task automatic t_iret(input logic s, input logic [1:0] en0,
                         input logic [1:0] en1);
      int c;
      do_reset();
      mem[0]   = {`CRRE_CALL_PREFIX, 11'd100};
      mem[101] = {`CRRE_IRET_BASE, s};
      apb(1'b1, `CRRE_OFF_ACC, 32'h11);
      apb(1'b1, `CRRE_OFF_STATUS, 32'h0a);
      apb(1'b1, `CRRE_OFF_BANK, 32'h3);
      apb(1'b1, `CRRE_OFF_ACC_SH, 32'h22);
      apb(1'b1, `CRRE_OFF_STAT_SH, 32'h15);
      apb(1'b1, `CRRE_OFF_BANK_SH, 32'hc);
      apb(1'b1, `CRRE_OFF_ENABLE, {30'h0, en0});
      apb(1'b1, `CRRE_OFF_HILATCH, 32'h5c);
      apb(1'b1, `CRRE_OFF_CTRL, 32'h1);
      wait_pc(21'd202, c);
      wait_pc(21'd2, c);
      apb(1'b1, `CRRE_OFF_CTRL, 32'h0);
      rd(`CRRE_OFF_ENABLE, {30'h0, en1}, "enables");
      rd(`CRRE_OFF_ACC, s ? 32'h22 : 32'h11, "acc");
      rd(`CRRE_OFF_STATUS, s ? 32'h15 : 32'h0a, "status");
      rd(`CRRE_OFF_BANK, s ? 32'hc : 32'h3, "bank");
      rd(`CRRE_OFF_STACK, 32'h0, "stack popped");
      rd(`CRRE_OFF_HILATCH, 32'h5c, "high latch");
      $display("test interrupt return s=%b done", s);
   endtask

   task automatic t_swrst();
      int c;
      do_reset();
      mem[0] = `CRRE_SWRST_WORD;
      apb(1'b1, `CRRE_OFF_ACC, 32'h5a);
      apb(1'b1, `CRRE_OFF_BANK, 32'h7);
      apb(1'b1, `CRRE_OFF_ENABLE, 32'h3);
      apb(1'b1, `CRRE_OFF_CTRL, 32'h1);
      c = 0;
      do
      begin
         @(negedge REF_CLK);
         c++;
      end
      while (SOFT_RESET !== 1'b1 && c < 40);
      chk("reset pulse", 32'h1, {31'h0, SOFT_RESET});
      chk("phase after reset", 32'(CRRE_Q1), 32'(CORE_PHASE));
      apb(1'b1, `CRRE_OFF_CTRL, 32'h0);
      rd(`CRRE_OFF_ACC, 32'h0, "acc cleared");
      rd(`CRRE_OFF_BANK, 32'h0, "bank cleared");
      rd(`CRRE_OFF_ENABLE, 32'h0, "enables cleared");
      $display("test software reset done");
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      RESET   = 1'b1;
      PSEL    = 1'b0;
      PENABLE = 1'b0;
      PWRITE  = 1'b0;
      PADDR   = 12'h000;
      PWDATA  = 32'h0;
      fail_count = 0;
      n_compared = 0;
      do_reset();
      t_regs();
      t_call(11'h3ff);
      t_call(11'h400);
      t_lret();
      t_iret(1'b1, 2'b00, 2'b10);
      t_iret(1'b0, 2'b10, 2'b11);
      t_swrst();
      report_and_stop();
   end

   // whole run needs a few hundred cycles
   initial
   begin
      #100us;
      fail_count++;
      report_and_stop();
   end
endmodule
